// *** core/apdsp_defines.svh ***
// constants of the active power signal path
`ifndef APDSP_DEFINES_SVH
`define APDSP_DEFINES_SVH
`define APD_CLK_HZ 100000000
`define APD_OSC_HZ 450000
`define APD_SAMPLE_DIV (`APD_CLK_HZ / `APD_OSC_HZ)
`define APD_DEC_RATIO 32
`define APD_DEC_SCALE 17
`define APD_HPF_SHIFT 10
`define APD_LPF_SHIFT 9
`define APD_MUL_DROP 18
`define APD_CF_RATIO_MAX 7
`define APD_PULSE_US 10
`define APD_PULSE_CYC ((`APD_PULSE_US * (`APD_CLK_HZ / 1000000)))
`define APD_FIFO_DEPTH 32
`endif

// *** core/apdsp_pkg.sv ***
// types of the active power signal path
package apdsp_pkg;
   typedef logic signed [23:0] apdsp_word_t;
   typedef logic signed [24:0] apdsp_hp_t;
   typedef logic signed [31:0] apdsp_pwr_t;
   typedef enum logic {APDSP_NEXT_F1, APDSP_NEXT_F2} apdsp_fphase_t;
endpackage : apdsp_pkg

// *** core/apdsp_fifo.sv ***
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module apdsp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!arst_n)
      cnt_r == (AW+1)'(DEPTH) && !pop |=> cnt_r == (AW+1)'(DEPTH))
      else $error("fifo count moved while full");
endmodule : apdsp_fifo
`default_nettype wire

// *** core/apdsp_top.sv ***
// active power path: decimation, hpf, multiply, lpf, pulse conversion
// Functional notes
// - each modulator bit is taken once per tick of the 450 kHz sampling rate.
// - a decimator averages modulator bits into 24-bit signed words.
// - the current channel passes a dc-removing high-pass filter.
// - instantaneous power is the product of the current and voltage words.
// - a low-pass filter extracts the dc term of instantaneous power.
// - positive active power is accumulated into slow f1/f2 pulses.
// - the calibration pulse uses a much shorter accumulation threshold.
// - the chain keeps the 40 Hz to 1 kHz band intact.
// - the decimated rate gives 7 kHz bandwidth, scaling with the sample rate.
// - multiply then filter yields true power at any power factor and harmonic.
// - the low-pass filter is single pole near 4.5 Hz.
// - the high-pass phase shift is compensated between channels.
`timescale 1ns/1ps
`default_nettype none
`include "apdsp_defines.svh"
module apdsp_top #(
   parameter int F_BASE_SHIFT = 30,
   parameter int PULSE_CYC = `APD_PULSE_CYC,
   parameter int FIFO_DEPTH = `APD_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cur_bit,
   input wire logic volt_bit,
   input wire logic [1:0] freq_sel,
   input wire logic cf_scale_sel,
   output apdsp_pkg::apdsp_pwr_t power_word,
   output logic power_valid,
   output logic calibration_pulse_output,
   output logic f1_pulse,
   output logic f2_pulse
);
   import apdsp_pkg::*;

   localparam int DIV = `APD_SAMPLE_DIV;
   localparam int DEC = `APD_DEC_RATIO;
   localparam int HS = `APD_HPF_SHIFT;
   localparam int LS = `APD_LPF_SHIFT;
   localparam int TICK_GAP = `APD_SAMPLE_DIV;

   logic [7:0] tick_cnt_r;
   logic tick;
   logic [4:0] dec_cnt_r;
   logic dec_stb_r;
   logic hpf_stb_r;
   logic mul_stb_r;
   logic [1:0] bits;
   apdsp_word_t word_r [2];
   apdsp_hp_t hp_r [2];
   apdsp_pwr_t inst_r;
   logic signed [49:0] prod;
   logic signed [31+LS:0] lpf_r;
   logic signed [31+LS:0] lpf_nxt;
   apdsp_pwr_t lpf_y;
   apdsp_pwr_t hold_r;
   logic hold_vld_r;
   logic fifo_in_ready;
   logic [31:0] drain_data;
   logic drain_valid;
   logic drain_ready;

   assign bits = {volt_bit, cur_bit};
   assign tick = (tick_cnt_r == 8'(DIV - 1));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dec_cnt_r <= '0;
         dec_stb_r <= 1'b0;
      end else begin
         dec_stb_r <= tick && (dec_cnt_r == 5'(DEC - 1));
         if (tick) begin
            dec_cnt_r <= dec_cnt_r + 1'b1;
         end
      end
   end

   // both channels get the same hpf so the phase shift cancels
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_ch
         logic [5:0] ones_r;
         logic [5:0] total;
         logic signed [7:0] diff;
         logic signed [23+HS:0] dc_r;
         apdsp_hp_t hp_nxt;
         assign total = ones_r + 6'(bits[ch]);
         assign diff = $signed({1'b0, total, 1'b0}) - 8'(DEC);
         assign hp_nxt = {word_r[ch][23], word_r[ch]}
            - {dc_r[23+HS], dc_r[23+HS:HS]};

         // integrate and dump over the decimation window
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               ones_r <= '0;
               word_r[ch] <= '0;
            end else if (tick) begin
               if (dec_cnt_r == 5'(DEC - 1)) begin
                  ones_r <= '0;
                  word_r[ch] <= {{16{diff[7]}}, diff} <<< `APD_DEC_SCALE;
               end else begin
                  ones_r <= total;
               end
            end
         end

         // dc tracker subtracted from the word
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               dc_r <= '0;
               hp_r[ch] <= '0;
            end else if (dec_stb_r) begin
               hp_r[ch] <= hp_nxt;
               dc_r <= dc_r + (24+HS)'(hp_nxt);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hpf_stb_r <= 1'b0;
         mul_stb_r <= 1'b0;
      end else begin
         hpf_stb_r <= dec_stb_r;
         mul_stb_r <= hpf_stb_r;
      end
   end

   assign prod = hp_r[0] * hp_r[1];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         inst_r <= '0;
      end else if (hpf_stb_r) begin
         inst_r <= 32'(prod >>> `APD_MUL_DROP);
      end
   end

   assign lpf_y = lpf_r[31+LS:LS];
   assign lpf_nxt = lpf_r + {{LS{inst_r[31]}}, inst_r}
      - {{LS{lpf_y[31]}}, lpf_y};
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lpf_r <= '0;
      end else if (mul_stb_r) begin
         lpf_r <= lpf_nxt;
      end
   end

   // filtered power held until the fifo takes it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_r <= '0;
         hold_vld_r <= 1'b0;
         power_word <= '0;
         power_valid <= 1'b0;
      end else begin
         power_valid <= mul_stb_r;
         if (mul_stb_r) begin
            hold_r <= lpf_nxt[31+LS:LS];
            hold_vld_r <= 1'b1;
            power_word <= lpf_nxt[31+LS:LS];
         end else if (fifo_in_ready) begin
            hold_vld_r <= 1'b0;
         end
      end
   end

   apdsp_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .in_data(hold_r),
      .in_valid(hold_vld_r),
      .in_ready(fifo_in_ready),
      .out_data(drain_data),
      .out_valid(drain_valid),
      .out_ready(drain_ready)
   );

   // digital-to-frequency conversion
   logic [47:0] acc_r;
   logic [47:0] thr;
   logic [5:0] cf_shift;
   logic [2:0] ratio_log;
   logic [15:0] cf_wid_r;
   logic [15:0] f_wid_r;
   logic [6:0] f_cnt_r;
   logic [6:0] f_last;
   logic cf_fire;
   apdsp_fphase_t fph_r;

   // cf threshold depends only on the scale select
   assign cf_shift = 6'(F_BASE_SHIFT - `APD_CF_RATIO_MAX + 32'(!cf_scale_sel));
   assign ratio_log = 3'(`APD_CF_RATIO_MAX) - 3'(freq_sel) - 3'(!cf_scale_sel);
   assign f_last = 7'((8'h01 << ratio_log) - 8'h01);
   assign thr = 48'h1 << cf_shift;
   assign cf_fire = (cf_wid_r == '0) && (acc_r >= thr);
   assign drain_ready = (cf_wid_r == '0) && !(acc_r >= thr);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_r <= '0;
      end else if (cf_fire) begin
         acc_r <= acc_r - thr;
      end else if (drain_valid && drain_ready && !drain_data[31]) begin
         acc_r <= acc_r + 48'(drain_data);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cf_wid_r <= '0;
      end else if (cf_fire) begin
         cf_wid_r <= 16'(PULSE_CYC);
      end else if (cf_wid_r != '0) begin
         cf_wid_r <= cf_wid_r - 1'b1;
      end
   end
   assign calibration_pulse_output = (cf_wid_r != '0);

   // f1/f2 alternate after 2^ratio cf pulses
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         f_cnt_r <= '0;
         f_wid_r <= '0;
         fph_r <= APDSP_NEXT_F1;
         f1_pulse <= 1'b0;
         f2_pulse <= 1'b0;
      end else begin
         if (f_wid_r != '0) begin
            f_wid_r <= f_wid_r - 1'b1;
         end else begin
            f1_pulse <= 1'b0;
            f2_pulse <= 1'b0;
         end
         if (cf_fire) begin
            if (f_cnt_r >= f_last) begin
               f_cnt_r <= '0;
               f_wid_r <= 16'(PULSE_CYC);
               unique case (fph_r)
                  APDSP_NEXT_F1: begin
                     f1_pulse <= 1'b1;
                     fph_r <= APDSP_NEXT_F2;
                  end
                  APDSP_NEXT_F2: begin
                     f2_pulse <= 1'b1;
                     fph_r <= APDSP_NEXT_F1;
                  end
               endcase
            end else begin
               f_cnt_r <= f_cnt_r + 1'b1;
            end
         end
      end
   end

   sequence s_cf_fire;
      (cf_wid_r == '0) && (acc_r >= thr);
   endsequence
   sequence s_mul_in;
      hpf_stb_r ##1 mul_stb_r;
   endsequence

   a_tick_period: assert property (@(posedge clk) disable iff (!arst_n)
      tick |-> ##TICK_GAP tick)
      else $error("sampling tick period wrong");
   a_dec_window: assert property (@(posedge clk) disable iff (!arst_n)
      dec_stb_r |-> $past(tick) && $past(dec_cnt_r) == 5'(DEC - 1))
      else $error("decimated word out of window");
   a_word_range: assert property (@(posedge clk) disable iff (!arst_n)
      dec_stb_r |-> word_r[0] <= 24'sh400000 && word_r[0] >= -24'sh400000)
      else $error("decimated word out of range");
   a_strobe_chain: assert property (@(posedge clk) disable iff (!arst_n)
      dec_stb_r |=> hpf_stb_r ##1 mul_stb_r ##1 power_valid)
      else $error("stage strobes misaligned");
   a_mul_product: assert property (@(posedge clk) disable iff (!arst_n)
      s_mul_in |-> inst_r == 32'($past(prod) >>> `APD_MUL_DROP))
      else $error("power product wrong");
   a_lpf_direction: assert property (@(posedge clk) disable iff (!arst_n)
      mul_stb_r && inst_r > lpf_y |=> lpf_y >= $past(lpf_y))
      else $error("lpf moved away from input");
   a_cf_fire: assert property (@(posedge clk) disable iff (!arst_n)
      s_cf_fire |=> calibration_pulse_output && acc_r == $past(acc_r) - $past(thr))
      else $error("cf pulse or accumulator wrong");
   a_drain_stall: assert property (@(posedge clk) disable iff (!arst_n)
      calibration_pulse_output |-> !drain_ready)
      else $error("drain not stalled during pulse");
   a_f_cause: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(f1_pulse) || $rose(f2_pulse) |-> $past(cf_fire)
         && $past(f_cnt_r) >= $past(f_last))
      else $error("f pulse without cf count");
endmodule : apdsp_top
`default_nettype wire

// *** verification/apdsp_mod_model.sv ***
// modulator bitstream model for one channel
`timescale 1ns/1ps
`default_nettype none
module apdsp_mod_model #(
   parameter int DIV = 222
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [1:0] mode,
   output logic bit_o
);
   int cnt_r;
   logic tog_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 0;
         tog_r <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == DIV - 1) ? 0 : cnt_r + 1;
         // toggle far from the sampling tick
         if (cnt_r == DIV / 2) begin
            tog_r <= ~tog_r;
         end
      end
   end
   always_comb begin
      case (mode)
         2'h0: bit_o = 1'b0;
         2'h1: bit_o = 1'b1;
         default: bit_o = tog_r;
      endcase
   end
endmodule : apdsp_mod_model
`default_nettype wire

// *** verification/active_power_dsp_path_tb_top.sv ***
// testbench of the active power signal path
`timescale 1ns/1ps
`default_nettype none
module active_power_dsp_path_tb_top;
   import apdsp_pkg::*;
   localparam int PCYC = 20;
   localparam int PERIOD = 7104;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [1:0] cur_mode = 2'h1;
   logic [1:0] volt_mode = 2'h1;
   logic [1:0] freq_sel = 2'h0;
   logic cf_scale_sel = 1'b0;
   logic cur_bit;
   logic volt_bit;
   apdsp_pwr_t power_word;
   logic power_valid;
   logic cal;
   logic f1;
   logic f2;
   logic f1_d = 1'b0;
   logic f2_d = 1'b0;
   int n_errors = 0;
   int n_compared = 0;
   int seed = 84999;
   int cyc = 0;
   int ratio = 0;
   int last_v = -1;
   int cf_rises = 0;
   int cf_since_f = -1;
   int cf_wid = 0;
   int nxt_f = 0;
   logic [1:0] exp_q[$];

   apdsp_mod_model cur_mod_u (.clk(clk), .arst_n(arst_n), .mode(cur_mode),
      .bit_o(cur_bit));
   apdsp_mod_model volt_mod_u (.clk(clk), .arst_n(arst_n),
      .mode(volt_mode), .bit_o(volt_bit));
   apdsp_top #(.F_BASE_SHIFT(12), .PULSE_CYC(PCYC)) dut_u (.clk(clk),
      .arst_n(arst_n), .cur_bit(cur_bit), .volt_bit(volt_bit),
      .freq_sel(freq_sel), .cf_scale_sel(cf_scale_sel),
      .power_word(power_word), .power_valid(power_valid),
      .calibration_pulse_output(cal), .f1_pulse(f1), .f2_pulse(f2));

   always #5 clk = ~clk;

   task automatic report_and_stop();
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk_sign(input string nm, input logic [1:0] e,
      input logic [1:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk_sign

   task automatic chk_count(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk_count

   function automatic logic [1:0] sign_of(input apdsp_pwr_t w);
      if (w === 32'h0) return 2'h0;
      if (w[31] === 1'b1) return 2'h2;
      if (w[31] === 1'b0) return 2'h1;
      return 2'h3;
   endfunction : sign_of

   always @(posedge clk) begin
      cyc++;
      if (!arst_n) begin
         last_v = -1;
         cf_wid = 0;
         cf_rises = 0;
         cf_since_f = -1;
         nxt_f = 0;
      end else begin
         if (power_valid === 1'b1) begin
            if (last_v >= 0) begin
               chk_count("power period", PERIOD, cyc - last_v);
            end
            last_v = cyc;
            if (exp_q.size() > 0) begin
               chk_sign("power sign", exp_q.pop_front(), sign_of(power_word));
            end
         end
         if (cal === 1'b1) begin
            if (cf_wid == 0) begin
               cf_rises++;
               cf_since_f += (cf_since_f >= 0) ? 1 : 0;
            end
            cf_wid++;
         end else if (cf_wid != 0) begin
            chk_count("cf width", PCYC, cf_wid);
            cf_wid = 0;
         end
         if ((f1 === 1'b1 && f1_d !== 1'b1) || (f2 === 1'b1 && f2_d !== 1'b1)) begin
            chk_count("f order", nxt_f, f2);
            nxt_f = (f2 === 1'b1) ? 0 : 1;
            if (cf_since_f >= 0) begin
               chk_count("cf per f", ratio, cf_since_f);
            end
            cf_since_f = 0;
         end
      end
      f1_d = f1;
      f2_d = f2;
      if (cyc == 95000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic run_case(input string nm, input logic [1:0] cm,
      input logic [1:0] vm, input int nw, input logic [1:0] es);
      int k;
      @(posedge clk);
      #1;
      arst_n = 1'b0;
      cur_mode = cm;
      volt_mode = vm;
      freq_sel = 2'($random(seed));
      cf_scale_sel = 1'($random(seed));
      ratio = 1 << (7 - int'(freq_sel) - int'(!cf_scale_sel));
      repeat (2) @(posedge clk);
      #1;
      chk_count("reset outputs", 32'h0, {power_valid, cal, f1, f2});
      chk_count("reset word", 32'h0, power_word);
      arst_n = 1'b1;
      for (k = 0; k < nw; k++) begin
         exp_q.push_back(es);
      end
      k = 0;
      while (exp_q.size() > 0 && k < nw * 8000) begin
         @(posedge clk);
         k++;
      end
      #1;
      chk_count("words left", 0, exp_q.size());
      chk_count("cf seen", es == 2'h1, cf_rises > 0);
      $display("end of %s, compared %0d", nm, n_compared);
   endtask : run_case

   initial begin
      run_case("positive power", 2'h1, 2'h1, 4, 2'h1);
      run_case("negative power", 2'h1, 2'h0, 3, 2'h2);
      run_case("zero voltage", 2'h1, 2'h2, 3, 2'h0);
      report_and_stop();
   end
endmodule : active_power_dsp_path_tb_top
`default_nettype wire
